// ==== src/pbm_pkg.sv ====
/*
 * Constants for the upper-half port pin block: register offsets, field
 * positions and reset values.
 * Assumes an 8-bit register port with a 4-bit address.
 */
package pbm_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int NPINS = 4;
   localparam int PIN_LO = 4;
   localparam int PIN_HI = 7;

   // Register offsets
   localparam logic [3:0] OFF_PIN_LEVEL = 4'h0;
   localparam logic [3:0] OFF_OUTPUT_LATCH = 4'h1;
   localparam logic [3:0] OFF_PIN_DIRECTION = 4'h2;
   localparam logic [3:0] OFF_INT_CTL_MAIN = 4'h3;
   localparam logic [3:0] OFF_INT_CTL_SECOND = 4'h4;
   localparam logic [3:0] OFF_INT_CTL_THIRD = 4'h5;
   localparam logic [3:0] OFF_ANALOG_SEL_LOW = 4'h6;
   localparam logic [3:0] OFF_ANALOG_SEL_HIGH = 4'h7;
   localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
   localparam logic [3:0] OFF_IRQ_MASK = 4'h9;

   // Field positions
   localparam int CTL_MAIN_FLAG_BIT = 0;
   localparam int CTL_MAIN_ENABLE_BIT = 3;
   localparam int CTL_SECOND_PUD_BIT = 7;
   localparam int CTL_SECOND_PRIO_BIT = 0;
   localparam int ANA_PIN4_BIT = 3;
   localparam int STAT_CHANGE_BIT = 0;

   // Index of each pin inside the upper nibble
   localparam int IDX_PIN4 = 0;
   localparam int IDX_PIN5 = 1;
   localparam int IDX_PIN6 = 2;
   localparam int IDX_PIN7 = 3;

   // Reset values
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'hff;
   localparam logic [7:0] RST_CTL = 8'h00;
   localparam logic [7:0] RST_ANALOG = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [3:0] ZERO_NIB = 4'h0;
endpackage

// ==== src/pbm_sync.sv ====
/*
 * Three-stage input synchroniser with agreement filter for one pin.
 * Assumes the input is asynchronous to mclk.
 */
`timescale 1ns/1ps
module pbm_sync (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic level
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Change is accepted only once stages two and three agree
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         level <= 1'b0;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end
endmodule

// ==== src/pbm_pin_cell.sv ====
/*
 * Output selection for one pin: drive value, enable and weak pull-up.
 * Assumes override requests are already qualified by the caller.
 */
`timescale 1ns/1ps
module pbm_pin_cell (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic dir_in,
   input wire logic latch_val,
   input wire logic analog_sel,
   input wire logic pud,
   input wire logic prog_own,
   input wire logic prog_oe,
   input wire logic prog_val,
   input wire logic pmp_en,
   input wire logic pmp_val,
   input wire logic remap_en,
   input wire logic remap_val,
   output logic pin_out,
   output logic pin_oe,
   output logic pullup_en
);
   logic next_out;
   logic next_oe;

   // Priority: programming, then parallel port, then remap, then latch
   always_comb begin
      next_out = latch_val;
      next_oe = ~dir_in;
      if (prog_own) begin
         next_out = prog_val;
         next_oe = prog_oe;
      end else if (pmp_en) begin
         next_out = pmp_val;
      end else if (remap_en) begin
         next_out = remap_val;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_out <= next_out;
         pin_oe <= next_oe;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pullup_en <= 1'b0;
      end else begin
         pullup_en <= dir_in & ~pud & ~analog_sel & ~prog_own;
      end
   end
endmodule

// ==== src/pbm_port_upper.sv ====
/*
 * Upper half (pins 4 to 7) of the general-purpose port: direction,
 * latch, read-back, pull-ups, analog default, change interrupt, parallel
 * port address, remappable slots and programming pins.
 * Assumes an 8-bit register port on mclk with read data one cycle later,
 * and that pins arrive asynchronously.
 */
// The plain strobed port and the register addresses are this design's own decisions.
//
// Operation
// - An input pin gets its weak pull-up while the pull-up disable bit is clear.
// - A pin selected as analog has its pull-up and digital input path off.
// - An output pin is driven from its latch bit, unaffected by analog selection.
// - Analog-capable pins come up analog after reset; software selects digital first.
// - Programming or debug mode removes every other function from the two programming pins.
// - In that mode the data pin is serial in and out, its direction set by debug logic.
// - With the slave port in use, input pins 4 and 5 feed the slave port address.
// - With the master port in use, output pins 4 and 5 drive address bits 1 and 0.
// - The small package has no parallel port address function on these pins.
// - Input pins 4 to 7 feed remappable peripheral inputs seven to ten.
// - Output pins 4 to 7 are driven by the peripheral output mapped to slots seven to ten.
`timescale 1ns/1ps
module pbm_port_upper (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   output logic change_irq_priority,
   input wire logic [3:0] pin_in,
   output logic [3:0] pin_out,
   output logic [3:0] pin_oe,
   output logic [3:0] pullup_en,
   input wire logic small_package,
   input wire logic par_slave_en,
   input wire logic par_master_en,
   input wire logic par_port_addr_1,
   input wire logic par_port_addr_0,
   output logic [1:0] par_slave_addr,
   output logic [3:0] remap_in,
   input wire logic [3:0] remap_out_en,
   input wire logic [3:0] remap_out,
   input wire logic serial_programming_mode,
   input wire logic debug_mode,
   output logic prog_clock_in,
   output logic prog_data_in,
   input wire logic prog_data_out,
   input wire logic prog_data_oe
);
   logic [7:0] output_latch;
   logic [7:0] pin_direction;
   logic [7:0] interrupt_control_main;
   logic [7:0] interrupt_control_second;
   logic [7:0] interrupt_control_third;
   logic [7:0] analog_select_low;
   logic [7:0] analog_select_high;
   logic change_irq_flag;

   logic [3:0] level;
   logic [3:0] prev_level;
   logic [3:0] prev_watch;
   logic [3:0] dir_up;
   logic [3:0] latch_up;
   logic [3:0] analog;
   logic [3:0] prog_own;
   logic [3:0] digital_ok;
   logic [3:0] watch;
   logic [3:0] pmp_drive;
   logic [3:0] pmp_val;
   logic [3:0] remap_drive;
   logic [3:0] prog_oe_v;
   logic [3:0] prog_val_v;
   logic prog_active;
   logic pmp_allowed;
   logic pud;
   logic change_irq_enable;
   logic change_event;
   logic flag_clear;
   logic [7:0] next_rdata;

   localparam int PIN_LO = pbm_pkg::PIN_LO;
   localparam int PIN_HI = pbm_pkg::PIN_HI;

   assign dir_up = pin_direction[PIN_HI:PIN_LO];
   assign latch_up = output_latch[PIN_HI:PIN_LO];
   assign pud = interrupt_control_second[pbm_pkg::CTL_SECOND_PUD_BIT];
   assign change_irq_enable = interrupt_control_main[pbm_pkg::CTL_MAIN_ENABLE_BIT];
   assign change_irq_priority = interrupt_control_second[pbm_pkg::CTL_SECOND_PRIO_BIT];

   // Only pin 4 is analog capable; select bit clear means analog
   assign analog = {3'h0, ~analog_select_high[pbm_pkg::ANA_PIN4_BIT]};

   // Programming pins belong to the debug logic alone
   assign prog_active = serial_programming_mode | debug_mode;
   assign prog_own = {prog_active, prog_active, 2'h0};

   // Digital input path off for analog or claimed pins
   assign digital_ok = ~analog & ~prog_own;
   assign watch = dir_up & digital_ok;

   // No parallel port address in the small package
   assign pmp_allowed = ~small_package;

   // Pin 4 carries address bit 1, pin 5 address bit 0
   assign pmp_drive = {2'h0, {2{par_master_en & pmp_allowed}} & ~dir_up[1:0]};
   assign pmp_val = {2'h0, par_port_addr_0, par_port_addr_1};

   // Mapped peripheral outputs on output pins
   assign remap_drive = remap_out_en & ~dir_up;

   // Only the data pin may be driven by the debug logic
   assign prog_oe_v = {prog_data_oe, 3'h0};
   assign prog_val_v = {prog_data_out, 3'h0};

   genvar gi;
   generate
      for (gi = 0; gi < pbm_pkg::NPINS; gi++) begin : g_pin
         pbm_sync u_sync (
            .mclk(mclk),
            .rst_n(rst_n),
            .async_in(pin_in[gi]),
            .level(level[gi])
         );
         pbm_pin_cell u_cell (
            .mclk(mclk),
            .rst_n(rst_n),
            .dir_in(dir_up[gi]),
            .latch_val(latch_up[gi]),
            .analog_sel(analog[gi]),
            .pud(pud),
            .prog_own(prog_own[gi]),
            .prog_oe(prog_oe_v[gi]),
            .prog_val(prog_val_v[gi]),
            .pmp_en(pmp_drive[gi]),
            .pmp_val(pmp_val[gi]),
            .remap_en(remap_drive[gi]),
            .remap_val(remap_out[gi]),
            .pin_out(pin_out[gi]),
            .pin_oe(pin_oe[gi]),
            .pullup_en(pullup_en[gi])
         );
      end
   endgenerate

   // Peripheral-facing inputs registered as data outputs
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         remap_in <= pbm_pkg::ZERO_NIB;
      end else begin
         // Input pins feed remap slots seven to ten
         remap_in <= level & watch;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         par_slave_addr <= 2'h0;
      end else begin
         // Slave address from input pins 4 and 5
         if (par_slave_en && pmp_allowed) begin
            par_slave_addr <= {level[pbm_pkg::IDX_PIN4] & watch[pbm_pkg::IDX_PIN4],
                               level[pbm_pkg::IDX_PIN5] & watch[pbm_pkg::IDX_PIN5]};
         end else begin
            par_slave_addr <= 2'h0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prog_clock_in <= 1'b0;
         prog_data_in <= 1'b0;
      end else begin
         // Serial data input while in programming mode
         prog_clock_in <= level[pbm_pkg::IDX_PIN6] & prog_active;
         prog_data_in <= level[pbm_pkg::IDX_PIN7] & prog_active;
      end
   end

   // Reference compared every cycle; enable must hold two cycles so a
   // direction or mode change does not fake a pin change
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prev_level <= pbm_pkg::ZERO_NIB;
         prev_watch <= pbm_pkg::ZERO_NIB;
      end else begin
         prev_level <= level;
         prev_watch <= watch;
      end
   end

   // Change on a watched input pin
   assign change_event = |((level ^ prev_level) & watch & prev_watch);
   assign flag_clear = reg_wr && (reg_addr == pbm_pkg::OFF_IRQ_STATUS) &&
                       reg_wdata[pbm_pkg::STAT_CHANGE_BIT];

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         change_irq_flag <= 1'b0;
      end else if (change_event) begin
         // Set wins over a clear in the same cycle
         change_irq_flag <= 1'b1;
      end else if (flag_clear) begin
         change_irq_flag <= 1'b0;
      end
   end

   assign irq = change_irq_flag & change_irq_enable;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         output_latch <= pbm_pkg::RST_LATCH;
      end else if (reg_wr && (reg_addr == pbm_pkg::OFF_PIN_LEVEL ||
                              reg_addr == pbm_pkg::OFF_OUTPUT_LATCH)) begin
         output_latch <= reg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pin_direction <= pbm_pkg::RST_DIRECTION;
      end else if (reg_wr && reg_addr == pbm_pkg::OFF_PIN_DIRECTION) begin
         pin_direction <= reg_wdata;
      end
   end

   // Enable bit shared by the main control and the mask register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         interrupt_control_main <= pbm_pkg::RST_CTL;
      end else if (reg_wr && reg_addr == pbm_pkg::OFF_INT_CTL_MAIN) begin
         interrupt_control_main <= reg_wdata;
      end else if (reg_wr && reg_addr == pbm_pkg::OFF_IRQ_MASK) begin
         interrupt_control_main[pbm_pkg::CTL_MAIN_ENABLE_BIT] <=
            reg_wdata[pbm_pkg::STAT_CHANGE_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         interrupt_control_second <= pbm_pkg::RST_CTL;
      end else if (reg_wr && reg_addr == pbm_pkg::OFF_INT_CTL_SECOND) begin
         interrupt_control_second <= reg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         interrupt_control_third <= pbm_pkg::RST_CTL;
      end else if (reg_wr && reg_addr == pbm_pkg::OFF_INT_CTL_THIRD) begin
         interrupt_control_third <= reg_wdata;
      end
   end

   // Analog selection reset to all analog
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         analog_select_low <= pbm_pkg::RST_ANALOG;
         analog_select_high <= pbm_pkg::RST_ANALOG;
      end else if (reg_wr && reg_addr == pbm_pkg::OFF_ANALOG_SEL_LOW) begin
         analog_select_low <= reg_wdata;
      end else if (reg_wr && reg_addr == pbm_pkg::OFF_ANALOG_SEL_HIGH) begin
         analog_select_high <= reg_wdata;
      end
   end

   always_comb begin
      next_rdata = pbm_pkg::ZERO_BYTE;
      case (reg_addr)
         // Pin states; lower pins live elsewhere
         pbm_pkg::OFF_PIN_LEVEL: next_rdata = {level & digital_ok, pbm_pkg::ZERO_NIB};
         pbm_pkg::OFF_OUTPUT_LATCH: next_rdata = output_latch;
         pbm_pkg::OFF_PIN_DIRECTION: next_rdata = pin_direction;
         pbm_pkg::OFF_INT_CTL_MAIN: begin
            next_rdata = interrupt_control_main;
            next_rdata[pbm_pkg::CTL_MAIN_FLAG_BIT] = change_irq_flag;
         end
         pbm_pkg::OFF_INT_CTL_SECOND: next_rdata = interrupt_control_second;
         pbm_pkg::OFF_INT_CTL_THIRD: next_rdata = interrupt_control_third;
         pbm_pkg::OFF_ANALOG_SEL_LOW: next_rdata = analog_select_low;
         pbm_pkg::OFF_ANALOG_SEL_HIGH: next_rdata = analog_select_high;
         pbm_pkg::OFF_IRQ_STATUS: next_rdata[pbm_pkg::STAT_CHANGE_BIT] = change_irq_flag;
         pbm_pkg::OFF_IRQ_MASK: next_rdata[pbm_pkg::STAT_CHANGE_BIT] = change_irq_enable;
         default: next_rdata = pbm_pkg::ZERO_BYTE;
      endcase
   end

   // Read data only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= pbm_pkg::ZERO_BYTE;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= pbm_pkg::ZERO_BYTE;
      end
   end
endmodule

// ==== verif/pbm_pin_model.sv ====
/* Board side of pins 4 to 7: external drivers and weak pull-ups.
   Assumes the chip wins any contention; the bench allows it only in the one cycle before a driven pin turns input. */
`timescale 1ns/1ps
module pbm_pin_model (
   input wire logic mclk,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic [3:0] pullup_en,
   input wire logic [3:0] ext_drv,
   input wire logic [3:0] ext_val,
   output logic [3:0] pin_in
);
   logic [3:0] flt = 4'h0;
   // Floating pin has no defined level
   always @(posedge mclk) flt <= ~flt;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] : pullup_en[i] | flt[i];
      end
   end
endmodule

// ==== verif/pbm_port_upper_properties.sv ====
/* Checker of the upper port pins.
   Assumes binding to pbm_port_upper, one mclk domain. */
`timescale 1ns/1ps
module pbm_port_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic irq,
   input wire logic change_irq_priority,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic [3:0] pullup_en,
   input wire logic small_package,
   input wire logic par_slave_en,
   input wire logic par_master_en,
   input wire logic par_port_addr_1,
   input wire logic par_port_addr_0,
   input wire logic [1:0] par_slave_addr,
   input wire logic serial_programming_mode,
   input wire logic debug_mode,
   input wire logic prog_clock_in,
   input wire logic prog_data_in,
   input wire logic prog_data_oe
);
   logic pm;
   assign pm = serial_programming_mode | debug_mode;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero after idle cycle");
   a_pullup_input_only: assert property ((pullup_en & pin_oe) == 4'h0)
      else $error("pull-up on a driven pin");
   a_prio_write: assert property (
      reg_wr && reg_addr == pbm_pkg::OFF_INT_CTL_SECOND
      |=> change_irq_priority == $past(reg_wdata[0]))
      else $error("priority bit not written");
   a_irq_disable: assert property (
      reg_wr && reg_addr == pbm_pkg::OFF_INT_CTL_MAIN && !reg_wdata[3] |=> !irq)
      else $error("irq stays high with enable cleared");
   a_slave_addr_off: assert property ((!par_slave_en || small_package) |=>
      par_slave_addr == 2'b00)
      else $error("slave address without slave port");
   a_master_addr_drive: assert property (
      par_master_en && !small_package ##1 &pin_oe[1:0]
      |-> pin_out[1:0] == {$past(par_port_addr_0), $past(par_port_addr_1)})
      else $error("master address not on pins 4 and 5");
   a_prog_idle: assert property (!pm |=> !prog_clock_in && !prog_data_in)
      else $error("programming input outside mode");
   a_prog_data_dir: assert property (pm |=> pin_oe[3] == $past(prog_data_oe))
      else $error("data pin direction not from debug logic");
   a_prog_clock_input: assert property (pm |=> !pin_oe[2])
      else $error("clock pin driven in programming mode");
endmodule
bind pbm_port_upper pbm_port_checker i_chk (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .irq, .change_irq_priority, .pin_out, .pin_oe, .pullup_en,
   .small_package, .par_slave_en, .par_master_en, .par_port_addr_1, .par_port_addr_0,
   .par_slave_addr, .serial_programming_mode, .debug_mode, .prog_clock_in, .prog_data_in,
   .prog_data_oe);

// ==== verif/pbm_port_upper_bench.sv ====
/* Bench of the upper port pins: registers, drive, inputs, change irq.
   Assumes pbm_pin_model on the pins and the bound checker. */
`timescale 1ns/1ps
module pbm_port_upper_bench;
   logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic small_package = 1'b0, par_slave_en = 1'b0, par_master_en = 1'b0;
   logic par_port_addr_1 = 1'b0, par_port_addr_0 = 1'b0, debug_mode = 1'b0;
   logic serial_programming_mode = 1'b0, prog_data_out = 1'b0, prog_data_oe = 1'b0;
   logic irq, change_irq_priority, prog_clock_in, prog_data_in;
   logic [3:0] reg_addr = 4'h0, remap_out_en = 4'h0, remap_out = 4'h0;
   logic [3:0] ext_drv = 4'h0, ext_val = 4'h0, pin_in, pin_out, pin_oe, pullup_en, remap_in;
   logic [1:0] par_slave_addr;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
   logic [7:0] exp_q[$];
   int n_errors = 0, checks_done = 0, seed = 12605;
   pbm_port_upper i_dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .irq, .change_irq_priority, .pin_in, .pin_out, .pin_oe, .pullup_en, .small_package,
      .par_slave_en, .par_master_en, .par_port_addr_1, .par_port_addr_0, .par_slave_addr,
      .remap_in, .remap_out_en, .remap_out, .serial_programming_mode, .debug_mode,
      .prog_clock_in, .prog_data_in, .prog_data_out, .prog_data_oe);
   pbm_pin_model i_pins (.mclk, .pin_out, .pin_oe, .pullup_en, .ext_drv, .ext_val, .pin_in);
   always #2.5 mclk = ~mclk;
   task automatic test_done();
      if (n_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic ck(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %0t mismatch got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Strobe edges never coincide: each call waits for a fresh edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask
   task automatic wirq(input logic l);
      int k;
      k = 0;
      while (irq !== l && k < 20) begin
         @(posedge mclk);
         k++;
      end
      ck({7'h00, irq}, {7'h00, l});
      if (irq !== l)
         test_done();
   endtask
   // Read data stands only in the cycle after the strobe
   always @(posedge mclk) begin
      if (rd_d)
         ck(reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd;
   end
   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      cyc(8);
      ck({pin_oe, pullup_en}, 8'h0e);
      rd(pbm_pkg::OFF_PIN_DIRECTION, 8'hff);
      rd(pbm_pkg::OFF_OUTPUT_LATCH, 8'h00);
      rd(pbm_pkg::OFF_ANALOG_SEL_HIGH, 8'h00);
      rd(4'hf, 8'h00);
      rd(pbm_pkg::OFF_PIN_LEVEL, 8'he0);
      wr(pbm_pkg::OFF_INT_CTL_SECOND, 8'h81);
      cyc(2);
      ck({3'h0, change_irq_priority, pullup_en}, 8'h10);
      wr(pbm_pkg::OFF_INT_CTL_SECOND, 8'h00);
      wr(pbm_pkg::OFF_ANALOG_SEL_HIGH, 8'h08);
      cyc(2);
      ck({4'h0, pullup_en}, 8'h0f);
      wr(pbm_pkg::OFF_PIN_DIRECTION, 8'h0f);
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         wr(i[0] ? pbm_pkg::OFF_PIN_LEVEL : pbm_pkg::OFF_OUTPUT_LATCH, v);
         cyc(2);
         ck({pin_oe, pin_out}, {4'hf, v[7:4]});
         rd(pbm_pkg::OFF_OUTPUT_LATCH, v);
      end
      cyc(6);
      rd(pbm_pkg::OFF_PIN_LEVEL, {v[7:4], 4'h0});
      wr(pbm_pkg::OFF_ANALOG_SEL_HIGH, 8'h00);
      cyc(2);
      ck({4'h0, pin_out}, {4'h0, v[7:4]});
      remap_out_en <= 4'hf;
      remap_out <= v[3:0];
      cyc(2);
      ck({4'h0, pin_out}, {4'h0, v[3:0]});
      par_master_en <= 1'b1;
      par_port_addr_1 <= 1'b1;
      cyc(2);
      ck({4'h0, pin_out}, {4'h0, v[3:2], 2'b01});
      small_package <= 1'b1;
      cyc(2);
      ck({4'h0, pin_out}, {4'h0, v[3:0]});
      par_master_en <= 1'b0;
      small_package <= 1'b0;
      remap_out_en <= 4'h0;
      wr(pbm_pkg::OFF_ANALOG_SEL_HIGH, 8'h08);
      wr(pbm_pkg::OFF_PIN_DIRECTION, 8'hff);
      ext_drv <= 4'hf;
      ext_val <= v[7:4];
      par_slave_en <= 1'b1;
      cyc(8);
      ck({4'h0, remap_in}, {4'h0, v[7:4]});
      ck({6'h00, par_slave_addr}, {6'h00, v[4], v[5]});
      rd(pbm_pkg::OFF_PIN_LEVEL, {v[7:4], 4'h0});
      small_package <= 1'b1;
      cyc(2);
      ck({6'h00, par_slave_addr}, 8'h00);
      small_package <= 1'b0;
      par_slave_en <= 1'b0;
      wr(pbm_pkg::OFF_IRQ_STATUS, 8'h01);
      wr(pbm_pkg::OFF_INT_CTL_MAIN, 8'h08);
      rd(pbm_pkg::OFF_IRQ_STATUS, 8'h00);
      ext_val <= ext_val ^ 4'h2;
      wirq(1'b1);
      rd(pbm_pkg::OFF_INT_CTL_MAIN, 8'h09);
      // Write lands on the last edge of wr; irq follows at that same edge and is checked one edge later
      wr(pbm_pkg::OFF_INT_CTL_MAIN, 8'h00);
      cyc(1);
      ck({7'h00, irq}, 8'h00);
      wr(pbm_pkg::OFF_IRQ_MASK, 8'h01);
      cyc(1);
      ck({7'h00, irq}, 8'h01);
      wr(pbm_pkg::OFF_IRQ_STATUS, 8'h01);
      cyc(1);
      ck({7'h00, irq}, 8'h00);
      wr(pbm_pkg::OFF_PIN_DIRECTION, 8'h0f);
      debug_mode <= 1'b1;
      prog_data_oe <= 1'b1;
      prog_data_out <= 1'b1;
      ext_drv <= 4'h0;
      cyc(2);
      ck({pin_oe, pin_out[3], 3'h0}, 8'hb8);
      serial_programming_mode <= 1'b1;
      debug_mode <= 1'b0;
      prog_data_oe <= 1'b0;
      ext_drv <= 4'hc;
      ext_val <= 4'h8;
      cyc(8);
      ck({pin_oe, 2'b00, prog_clock_in, prog_data_in}, 8'h31);
      ext_val <= 4'h4;
      cyc(8);
      ck({6'h00, prog_clock_in, prog_data_in}, 8'h02);
      serial_programming_mode <= 1'b0;
      ext_drv <= 4'h0;
      cyc(2);
      ck({pin_oe, 4'h0}, 8'hf0);
      cyc(4);
      test_done();
   end
endmodule
